/* hdl/arpr_pkg.sv */
// Purpose: Constants and types for the audio record and power register bank.
// Assumes: Register indexes are the 7-bit addresses carried in the link's command address slot.
// Notes: Times are in microseconds; cycle counts are derived from the 50 MHz clock.
// Summary of operation
// - Left source field: 000 takes microphone, 100 takes left line, others reserved.
// - Right source field: 000 copies left, 100 takes right line, others reserved.
// - Right source 000 gives mono; gain then follows the left setting only.
// - Left record gain field is a 4-bit code in 1.5 dB steps.
// - Right record gain field is a 4-bit code in 1.5 dB steps.
// - Loopback bit feeds the ADC output straight into the DAC input.
// - Power-down bits stop link output, reference, DAC path and ADC path; the clock-off bit only drives o_power.
// - Low byte of power register reports reference, DAC and ADC readiness.
// - Writes to the power register leave its low status byte untouched.
// - Codec ready is raised a fixed 2 us after reset, whatever the power and readiness bits say.
package arpr_pkg;

    localparam logic [6:0]  IDX_REC_SRC    = 7'h1a;
    localparam logic [6:0]  IDX_REC_GAIN   = 7'h1c;
    localparam logic [6:0]  IDX_GENERAL    = 7'h20;
    localparam logic [6:0]  IDX_POWER      = 7'h26;

    localparam logic [15:0] RST_REC_SRC    = 16'h0000;
    localparam logic [15:0] RST_REC_GAIN   = 16'h8000;
    localparam logic [15:0] RST_GENERAL    = 16'h0000;
    localparam logic [15:0] RST_POWER      = 16'h0000;

    // Field positions (lowest bit of each field).
    localparam int          POS_SRC_L      = 8;
    localparam int          POS_SRC_R      = 0;
    localparam int          POS_MUTE       = 15;
    localparam int          POS_GAIN_L     = 8;
    localparam int          POS_GAIN_R     = 0;
    localparam int          POS_LOOP       = 7;
    localparam int          POS_CLK_OFF    = 13;
    localparam int          POS_LINK_PD    = 12;
    localparam int          POS_REF_PD     = 11;
    localparam int          POS_DAC_PD     = 9;
    localparam int          POS_ADC_PD     = 8;
    localparam int          POS_REF_RDY    = 3;
    localparam int          POS_DAC_RDY    = 1;
    localparam int          POS_ADC_RDY    = 0;

    localparam logic [2:0]  SRC_MIC        = 3'h0;
    localparam logic [2:0]  SRC_COPY_LEFT  = 3'h0;
    localparam logic [2:0]  SRC_LINE       = 3'h4;

    // Link frame layout in bit positions counted from the first bit of slot 0.
    localparam int          SLOT0_BITS     = 16;
    localparam int          SLOT_BITS      = 20;
    localparam logic [7:0]  END_SLOT0      = 8'h0f;
    localparam logic [7:0]  END_SLOT1      = 8'h23;
    localparam logic [7:0]  END_SLOT2      = 8'h37;
    localparam logic [7:0]  END_SLOT3      = 8'h4b;
    localparam logic [7:0]  END_SLOT4      = 8'h5f;
    localparam int          TAG_READY      = 15;
    localparam int          TAG_SLOT1      = 14;
    localparam int          TAG_SLOT2      = 13;
    localparam int          TAG_SLOT3      = 12;
    localparam int          TAG_SLOT4      = 11;

    localparam int          CLK_MHZ        = 50;
    localparam int          CODEC_READY_US = 2;
    localparam int          REF_SETTLE_US  = 1;
    localparam logic [7:0]  CODEC_READY_CYC = 8'(CODEC_READY_US * CLK_MHZ);
    localparam logic [7:0]  REF_SETTLE_CYC  = 8'(REF_SETTLE_US * CLK_MHZ);

    typedef struct packed {
        logic [19:0] left;
        logic [19:0] right;
    } arpr_stereo_type;

    typedef struct packed {
        logic [3:0] left;
        logic [3:0] right;
    } arpr_gain_type;

    typedef struct packed {
        logic internal_clock_off;
        logic link_power_down;
        logic audio_reference_power_down;
        logic playback_path_power_down;
        logic capture_path_power_down;
    } arpr_power_type;

endpackage

/* hdl/arpr_regs.sv */
// Purpose: Record source, record gain, loopback and power registers behind the serial audio link.
// Assumes: Bit clock, sync and serial data come from the host and are sampled by i_clk.
// Notes: Host data is taken on bit clock falling edges; returned data changes on rising edges.
module arpr_regs (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_n,
    input  wire logic                      i_bit_clk,
    input  wire logic                      i_sync,
    input  wire logic                      i_sdata_out,
    input  wire logic [19:0]               i_mic_sample,
    input  wire arpr_pkg::arpr_stereo_type i_line_sample,
    output logic                           o_sdata_in,
    output logic                           o_codec_ready,
    output arpr_pkg::arpr_stereo_type      o_rec_sample,
    output arpr_pkg::arpr_gain_type        o_rec_gain,
    output arpr_pkg::arpr_stereo_type      o_dac_sample,
    output logic                           o_loop_enable,
    output arpr_pkg::arpr_power_type       o_power
);

    logic [2:0]                left_record_source_sel;
    logic [2:0]                right_record_source_sel;
    logic                      record_mute_bit;
    logic [3:0]                left_record_gain;
    logic [3:0]                right_record_gain;
    logic                      adc_to_dac_loop_enable;
    arpr_pkg::arpr_power_type  pwr;
    logic                      ref_rdy;
    logic                      dac_rdy;
    logic                      adc_rdy;
    logic [7:0]                ref_cnt;
    logic [7:0]                rdy_cnt;

    logic [2:0]                bclk_s;
    logic [1:0]                sync_s;
    logic [1:0]                sdo_s;
    logic                      sync_prev;
    logic [7:0]                cnt;
    logic [18:0]               shift_in;
    logic                      tag_a;
    logic                      tag_d;
    logic [19:0]               cmd_addr;
    logic                      stat_valid;
    logic                      stat_send;
    logic [6:0]                stat_addr;
    logic [15:0]               stat_data;
    arpr_pkg::arpr_stereo_type dac_link;

    function automatic logic [15:0] reg_read(input logic [6:0] idx, input logic [15:0] src, input logic [15:0] gain,
                                             input logic [15:0] gen, input logic [15:0] pw);
        logic [15:0] r;
        r = 16'h0000;
        case (idx)
            arpr_pkg::IDX_REC_SRC:  r = src;
            arpr_pkg::IDX_REC_GAIN: r = gain;
            arpr_pkg::IDX_GENERAL:  r = gen;
            arpr_pkg::IDX_POWER:    r = pw;
            default:                r = 16'h0000;
        endcase
        return r;
    endfunction

    // Reserved positions are never stored, so they read back as zero.
    wire [15:0] rd_src   = (16'(left_record_source_sel) << arpr_pkg::POS_SRC_L)
                         | (16'(right_record_source_sel) << arpr_pkg::POS_SRC_R);
    wire [15:0] rd_gain  = (16'(record_mute_bit) << arpr_pkg::POS_MUTE)
                         | (16'(left_record_gain) << arpr_pkg::POS_GAIN_L)
                         | (16'(right_record_gain) << arpr_pkg::POS_GAIN_R);
    wire [15:0] rd_gen   = 16'(adc_to_dac_loop_enable) << arpr_pkg::POS_LOOP;
    wire [15:0] rd_pwr   = (16'(pwr.internal_clock_off) << arpr_pkg::POS_CLK_OFF)
                         | (16'(pwr.link_power_down) << arpr_pkg::POS_LINK_PD)
                         | (16'(pwr.audio_reference_power_down) << arpr_pkg::POS_REF_PD)
                         | (16'(pwr.playback_path_power_down) << arpr_pkg::POS_DAC_PD)
                         | (16'(pwr.capture_path_power_down) << arpr_pkg::POS_ADC_PD)
                         | (16'(ref_rdy) << arpr_pkg::POS_REF_RDY)
                         | (16'(dac_rdy) << arpr_pkg::POS_DAC_RDY)
                         | (16'(adc_rdy) << arpr_pkg::POS_ADC_RDY);

    // Edge detection works on the second and third stages only.
    wire        bclk_rise   = bclk_s[1] & ~bclk_s[2];
    wire        bclk_fall   = ~bclk_s[1] & bclk_s[2];
    wire        frame_start = sync_s[1] & ~sync_prev;
    wire [7:0]  next_cnt    = frame_start ? 8'h00 : ((cnt == 8'hff) ? cnt : cnt + 8'h01);
    wire [19:0] rx_word     = {shift_in, sdo_s[1]};
    wire [6:0]  cmd_idx     = cmd_addr[18:12];
    wire [15:0] wr_data     = rx_word[19:4];
    wire        wr_strobe   = bclk_fall && next_cnt == arpr_pkg::END_SLOT2 && tag_a && tag_d && !cmd_addr[19];
    wire        rd_strobe   = bclk_fall && next_cnt == arpr_pkg::END_SLOT1 && tag_a && rx_word[19];

    // Outgoing bit: the first bit of slot 0 goes out with the edge that raises sync.
    wire [7:0]  oidx        = (sync_s[1] & ~sync_prev) ? 8'h00 : cnt + 8'h01;
    wire        adc_ok      = adc_rdy & ~pwr.capture_path_power_down;
    wire [15:0] tx_slot0    = (16'(o_codec_ready) << arpr_pkg::TAG_READY)
                            | (16'(stat_send) << arpr_pkg::TAG_SLOT1)
                            | (16'(stat_send) << arpr_pkg::TAG_SLOT2)
                            | (16'(adc_ok) << arpr_pkg::TAG_SLOT3)
                            | (16'(adc_ok) << arpr_pkg::TAG_SLOT4);
    wire [99:0] tx_frame    = {tx_slot0[15:0], 1'b0, stat_addr, 12'h000, stat_data, 4'h0,
                               o_rec_sample.left, o_rec_sample.right, 4'h0};
    wire        tx_bit      = (oidx < 8'h60) ? tx_frame[7'h63 - oidx[6:0]] : 1'b0;

    // Record path selection.
    wire [19:0] sel_left    = (left_record_source_sel == arpr_pkg::SRC_MIC)  ? i_mic_sample :
                              (left_record_source_sel == arpr_pkg::SRC_LINE) ? i_line_sample.left : 20'h00000;
    wire [19:0] sel_right   = (right_record_source_sel == arpr_pkg::SRC_COPY_LEFT) ? sel_left :
                              (right_record_source_sel == arpr_pkg::SRC_LINE) ? i_line_sample.right : 20'h00000;
    wire        rec_silent  = record_mute_bit | pwr.capture_path_power_down;
    wire        mono        = right_record_source_sel == arpr_pkg::SRC_COPY_LEFT;
    arpr_pkg::arpr_stereo_type next_rec;
    arpr_pkg::arpr_stereo_type next_dac;
    assign next_rec.left   = rec_silent ? 20'h00000 : sel_left;
    assign next_rec.right  = rec_silent ? 20'h00000 : sel_right;
    // Loopback bypasses the link entirely; playback power-down still wins.
    assign next_dac        = pwr.playback_path_power_down ? 40'h0 :
                             (adc_to_dac_loop_enable ? o_rec_sample : dac_link);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bclk_s <= 3'h0;
            sync_s <= 2'h0;
            sdo_s  <= 2'h0;
        end else begin
            bclk_s <= {bclk_s[1:0], i_bit_clk};
            sync_s <= {sync_s[0], i_sync};
            sdo_s  <= {sdo_s[0], i_sdata_out};
        end
    end

    // Host-to-device frame reception.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_prev <= 1'b0;
            cnt       <= 8'hff;
            shift_in  <= 19'h00000;
            tag_a     <= 1'b0;
            tag_d     <= 1'b0;
            cmd_addr  <= 20'h00000;
            dac_link  <= 40'h0;
        end else if (bclk_fall) begin
            sync_prev <= sync_s[1];
            cnt       <= next_cnt;
            shift_in  <= rx_word[18:0];
            if (next_cnt == arpr_pkg::END_SLOT0) begin
                tag_a <= rx_word[arpr_pkg::TAG_SLOT1];
                tag_d <= rx_word[arpr_pkg::TAG_SLOT2];
            end
            if (next_cnt == arpr_pkg::END_SLOT1)
                cmd_addr <= rx_word;
            if (next_cnt == arpr_pkg::END_SLOT3)
                dac_link.left <= rx_word;
            if (next_cnt == arpr_pkg::END_SLOT4)
                dac_link.right <= rx_word;
        end
    end

    // A read answered in slot 0 tags and slots 1 and 2 of the following frame.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stat_valid <= 1'b0;
            stat_send  <= 1'b0;
            stat_addr  <= 7'h00;
            stat_data  <= 16'h0000;
        end else if (rd_strobe) begin
            stat_valid <= 1'b1;
            stat_addr  <= rx_word[18:12];
            stat_data  <= reg_read(rx_word[18:12], rd_src, rd_gain, rd_gen, rd_pwr);
        end else if (bclk_fall && frame_start) begin
            stat_send  <= stat_valid;
            stat_valid <= 1'b0;
        end
    end

    // Register writes keep only defined fields.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            left_record_source_sel  <= arpr_pkg::RST_REC_SRC[arpr_pkg::POS_SRC_L +: 3];
            right_record_source_sel <= arpr_pkg::RST_REC_SRC[arpr_pkg::POS_SRC_R +: 3];
            record_mute_bit         <= arpr_pkg::RST_REC_GAIN[arpr_pkg::POS_MUTE];
            left_record_gain        <= arpr_pkg::RST_REC_GAIN[arpr_pkg::POS_GAIN_L +: 4];
            right_record_gain       <= arpr_pkg::RST_REC_GAIN[arpr_pkg::POS_GAIN_R +: 4];
            adc_to_dac_loop_enable  <= arpr_pkg::RST_GENERAL[arpr_pkg::POS_LOOP];
            pwr                     <= 5'h00;
        end else if (wr_strobe) begin
            case (cmd_idx)
                arpr_pkg::IDX_REC_SRC: begin
                    left_record_source_sel  <= wr_data[arpr_pkg::POS_SRC_L +: 3];
                    right_record_source_sel <= wr_data[arpr_pkg::POS_SRC_R +: 3];
                end
                arpr_pkg::IDX_REC_GAIN: begin
                    record_mute_bit   <= wr_data[arpr_pkg::POS_MUTE];
                    left_record_gain  <= wr_data[arpr_pkg::POS_GAIN_L +: 4];
                    right_record_gain <= wr_data[arpr_pkg::POS_GAIN_R +: 4];
                end
                arpr_pkg::IDX_GENERAL:
                    adc_to_dac_loop_enable <= wr_data[arpr_pkg::POS_LOOP];
                arpr_pkg::IDX_POWER: begin
                    // The low status byte is never taken from the written word.
                    pwr.internal_clock_off         <= wr_data[arpr_pkg::POS_CLK_OFF];
                    pwr.link_power_down            <= wr_data[arpr_pkg::POS_LINK_PD];
                    pwr.audio_reference_power_down <= wr_data[arpr_pkg::POS_REF_PD];
                    pwr.playback_path_power_down   <= wr_data[arpr_pkg::POS_DAC_PD];
                    pwr.capture_path_power_down    <= wr_data[arpr_pkg::POS_ADC_PD];
                end
                default: ;
            endcase
        end
    end

    // Readiness: the reference needs a settle time; the paths follow it.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ref_cnt       <= 8'h00;
            ref_rdy       <= 1'b0;
            dac_rdy       <= 1'b0;
            adc_rdy       <= 1'b0;
            rdy_cnt       <= 8'h00;
            o_codec_ready <= 1'b0;
        end else begin
            if (pwr.audio_reference_power_down)
                ref_cnt <= 8'h00;
            else if (ref_cnt != arpr_pkg::REF_SETTLE_CYC)
                ref_cnt <= ref_cnt + 8'h01;
            ref_rdy <= !pwr.audio_reference_power_down && ref_cnt == arpr_pkg::REF_SETTLE_CYC;
            dac_rdy <= ref_rdy && !pwr.playback_path_power_down;
            adc_rdy <= ref_rdy && !pwr.capture_path_power_down;
            if (rdy_cnt != arpr_pkg::CODEC_READY_CYC)
                rdy_cnt <= rdy_cnt + 8'h01;
            o_codec_ready <= rdy_cnt == arpr_pkg::CODEC_READY_CYC;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sdata_in    <= 1'b0;
            o_rec_sample  <= 40'h0;
            o_rec_gain    <= 8'h00;
            o_dac_sample  <= 40'h0;
            o_loop_enable <= 1'b0;
            o_power       <= 5'h00;
        end else begin
            if (pwr.link_power_down)
                o_sdata_in <= 1'b0;
            else if (bclk_rise)
                o_sdata_in <= tx_bit;
            o_rec_sample     <= next_rec;
            o_rec_gain.left  <= left_record_gain;
            o_rec_gain.right <= mono ? left_record_gain : right_record_gain;
            o_dac_sample     <= next_dac;
            o_loop_enable    <= adc_to_dac_loop_enable;
            o_power          <= pwr;
        end
    end

endmodule

/* bench/arpr_regs_asserts.sv */
// Purpose: Port-level checks for the record and power register bank.
// Assumes: Sample inputs are held steady for long stretches between changes.
// Notes: Reset-window checks rely on no link write landing within 200 clocks.
module arpr_regs_asserts (
    input wire logic                      i_clk,
    input wire logic                      i_rst_n,
    input wire logic                      i_bit_clk,
    input wire logic                      i_sync,
    input wire logic                      i_sdata_out,
    input wire logic [19:0]               i_mic_sample,
    input wire arpr_pkg::arpr_stereo_type i_line_sample,
    input wire logic                      o_sdata_in,
    input wire logic                      o_codec_ready,
    input wire arpr_pkg::arpr_stereo_type o_rec_sample,
    input wire arpr_pkg::arpr_gain_type   o_rec_gain,
    input wire arpr_pkg::arpr_stereo_type o_dac_sample,
    input wire logic                      o_loop_enable,
    input wire arpr_pkg::arpr_power_type  o_power
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    logic [8:0] since_rst;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) since_rst <= 9'h000;
        else if (since_rst != 9'h1ff) since_rst <= since_rst + 9'h001;
    end

    ready_early_a: assert property (since_rst < 9'h020 |-> !o_codec_ready)
        else $error("codec ready raised too early");
    ready_late_a: assert property (since_rst == 9'h0fa |-> o_codec_ready)
        else $error("codec ready missing");
    ready_hold_a: assert property (o_codec_ready |=> o_codec_ready)
        else $error("codec ready dropped");
    reset_quiet_a: assert property (since_rst < 9'h0c8 |-> o_rec_sample == '0 && o_rec_gain == '0
        && o_power == '0 && !o_loop_enable) else $error("record path not quiet after reset");
    link_quiet_a: assert property (o_power.link_power_down [*3] |-> !o_sdata_in)
        else $error("serial data active while link powered down");
    adc_off_a: assert property (o_power.capture_path_power_down [*2] |-> o_rec_sample == '0)
        else $error("record data while capture path down");
    dac_off_a: assert property (o_power.playback_path_power_down [*2] |-> o_dac_sample == '0)
        else $error("dac data while playback path down");
    loop_path_a: assert property ((o_loop_enable && !o_power.playback_path_power_down
        && $stable(o_rec_sample)) [*3] |-> o_dac_sample == o_rec_sample) else $error("loopback mismatch");
    left_route_a: assert property (($stable(i_mic_sample) && $stable(i_line_sample)) [*3]
        |-> o_rec_sample.left inside {20'h00000, i_mic_sample, i_line_sample.left}) else $error("left source");
    right_route_a: assert property (($stable(i_mic_sample) && $stable(i_line_sample)) [*3]
        |-> o_rec_sample.right inside {20'h00000, o_rec_sample.left, i_line_sample.right})
        else $error("right source");
endmodule

bind arpr_regs arpr_regs_asserts u_asserts (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bit_clk(i_bit_clk),
    .i_sync(i_sync), .i_sdata_out(i_sdata_out), .i_mic_sample(i_mic_sample), .i_line_sample(i_line_sample),
    .o_sdata_in(o_sdata_in), .o_codec_ready(o_codec_ready), .o_rec_sample(o_rec_sample),
    .o_rec_gain(o_rec_gain), .o_dac_sample(o_dac_sample), .o_loop_enable(o_loop_enable), .o_power(o_power));

/* bench/arpr_host_model.sv */
// Purpose: Host side of the serial audio link: bit clock, sync and command data.
// Assumes: Frames are sent one at a time; the bit clock stands still between frames.
// Notes: Returned bits are sampled just before the next rising edge, well after the launch delay.
module arpr_host_model (
    output logic      o_bit_clk,
    output logic      o_sync,
    output logic      o_sdata_out,
    input  wire logic i_sdata_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_bit_clk = 1'b0;
        o_sync = 1'b0;
        o_sdata_out = 1'b0;
    end

    // Tag slot then four 20-bit slots, MSB first; the frame is padded to 128 bits.
    task automatic xfer(input logic [95:0] tx, output logic [95:0] rx);
        #7;
        for (int i = 0; i < 128; i++) begin
            o_bit_clk = 1'b1;
            o_sync = (i < 16);
            o_sdata_out = (i < 96) ? tx[95-i] : 1'b0;
            #80;
            o_bit_clk = 1'b0;
            #70;
            if (i < 96) rx[95-i] = i_sdata_in;
            #10;
        end
    endtask
endmodule

/* bench/tb_top.sv */
// Purpose: Self-checking bench for the record and power register bank.
// Assumes: Commands reach the block only through the host link model.
// Notes: One command per frame; a read answer is taken from the following frame.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [19:0] MIC = 20'h12345;
    localparam logic [19:0] LL  = 20'h6789a;
    localparam logic [19:0] LR  = 20'hbcdef;
    logic                      i_clk, i_rst_n, bit_clk, sync, sdata_out, sdata_in, codec_ready, loop_en;
    logic [19:0]               mic;
    arpr_pkg::arpr_stereo_type line, rec, dac;
    arpr_pkg::arpr_gain_type   gain;
    arpr_pkg::arpr_power_type  power;
    logic [95:0]               rx;
    int                        bad_count = 0;
    int                        tests_run = 0;
    logic [15:0]               src_tab [5] = '{16'h0000, 16'h0404, 16'h0204, 16'h0402, 16'h0400};
    logic [39:0]               exp_tab [5] = '{{MIC, MIC}, {LL, LR}, {20'h0, LR}, {LL, 20'h0}, {LL, LL}};

    arpr_regs u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bit_clk(bit_clk), .i_sync(sync),
        .i_sdata_out(sdata_out), .i_mic_sample(mic), .i_line_sample(line), .o_sdata_in(sdata_in),
        .o_codec_ready(codec_ready), .o_rec_sample(rec), .o_rec_gain(gain), .o_dac_sample(dac),
        .o_loop_enable(loop_en), .o_power(power));
    arpr_host_model u_host (.o_bit_clk(bit_clk), .o_sync(sync), .o_sdata_out(sdata_out), .i_sdata_in(sdata_in));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (bad_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Frames start a little after a clock edge so outputs are read where they are settled.
    task automatic xf(input logic [15:0] s0, input logic [19:0] s1, s2, s3, s4);
        @(posedge i_clk);
        #4;
        u_host.xfer({s0, s1, s2, s3, s4}, rx);
    endtask

    task automatic wr(input logic [6:0] idx, input logic [15:0] d);
        xf(16'he000, {1'b0, idx, 12'h000}, {d, 4'h0}, 20'h0, 20'h0);
    endtask

    task automatic rd(input logic [6:0] idx, input logic [15:0] exp);
        xf(16'hc000, {1'b1, idx, 12'h000}, 20'h0, 20'h0, 20'h0);
        xf(16'h0000, 20'h0, 20'h0, 20'h0, 20'h0);
        chk({rx[94:93], rx[78:72], rx[59:44]}, {2'h3, idx, exp});
    endtask

    task automatic t_start();
        int n;
        for (n = 0; n < 500 && codec_ready !== 1'b1; n++) @(posedge i_clk);
        if (n == 500) begin
            bad_count++;
            end_sim();
        end
        xf(16'h0000, 20'h0, 20'h0, 20'h0, 20'h0);
        chk(rx[95], 1'b1);
        rd(arpr_pkg::IDX_REC_SRC, 16'h0000);
        rd(arpr_pkg::IDX_REC_GAIN, 16'h8000);
        rd(arpr_pkg::IDX_GENERAL, 16'h0000);
        rd(arpr_pkg::IDX_POWER, 16'h000b);
    endtask

    task automatic t_route();
        wr(arpr_pkg::IDX_REC_GAIN, 16'h0000);
        foreach (src_tab[k]) begin
            wr(arpr_pkg::IDX_REC_SRC, src_tab[k]);
            chk(rec, exp_tab[k]);
        end
        wr(arpr_pkg::IDX_REC_GAIN, 16'h8000);
        chk(rec, 40'h0);
        wr(arpr_pkg::IDX_REC_SRC, 16'hffff);
        rd(arpr_pkg::IDX_REC_SRC, 16'h0707);
    endtask

    task automatic t_gain();
        wr(arpr_pkg::IDX_REC_SRC, 16'h0404);
        wr(arpr_pkg::IDX_REC_GAIN, 16'h7fff);
        rd(arpr_pkg::IDX_REC_GAIN, 16'h0f0f);
        chk(gain, 8'hff);
        wr(arpr_pkg::IDX_REC_GAIN, 16'h0a05);
        chk(gain, 8'ha5);
        wr(arpr_pkg::IDX_REC_SRC, 16'h0400);
        chk(gain, 8'haa);
    endtask

    task automatic t_loop();
        wr(arpr_pkg::IDX_GENERAL, 16'h0000);
        xf(16'h9800, 20'h0, 20'h0, 20'h13579, 20'h2468a);
        chk(dac, {20'h13579, 20'h2468a});
        wr(arpr_pkg::IDX_GENERAL, 16'hffff);
        rd(arpr_pkg::IDX_GENERAL, 16'h0080);
        chk({loop_en, dac}, {1'b1, LL, LL});
    endtask

    task automatic t_power();
        wr(arpr_pkg::IDX_POWER, 16'hc4f4);
        rd(arpr_pkg::IDX_POWER, 16'h000b);
        wr(arpr_pkg::IDX_POWER, 16'hffff);
        chk({power, rec, dac}, {5'h1f, 80'h0});
        xf(16'h0000, 20'h0, 20'h0, 20'h0, 20'h0);
        chk(rx, 96'h0);
        wr(arpr_pkg::IDX_POWER, 16'h0000);
        rd(arpr_pkg::IDX_POWER, 16'h000b);
    endtask

    initial begin
        i_rst_n <= 1'b0;
        mic <= MIC;
        line <= {LL, LR};
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_start();
        t_route();
        t_gain();
        t_loop();
        t_power();
        end_sim();
    end
endmodule
